// *** common/eir_consts.svh ***
/*
 * Constants of the external and internal interrupt front end: register
 * indices, reset values and timing counts.
 * Assumes a single 250 MHz pclk; included by the package and the design files.
 */
`ifndef EIR_CONSTS_SVH
`define EIR_CONSTS_SVH

`define EIR_CLK_NS 4
`define EIR_T_INSTR_NS 1780
`define EIR_INSTR_CYC (`EIR_T_INSTR_NS / `EIR_CLK_NS)
`define EIR_T_FILT_NS 100
`define EIR_FILT_CYC ((`EIR_T_FILT_NS + `EIR_CLK_NS - 1) / `EIR_CLK_NS)

`define EIR_PC_W 14
`define EIR_ADDR_W 12
`define EIR_IDX_W 10
`define EIR_NSRC 12

`define EIR_IDX_REQ 10'h010
`define EIR_IDX_EN 10'h011
`define EIR_IDX_STAT 10'h012
`define EIR_IDX_LVL 10'h013
`define EIR_IDX_EDGE_HI 10'h014
`define EIR_IDX_TMR0 10'h018
`define EIR_IDX_EDGE 10'h01f

`define EIR_STAT_SP_POS 8
`define EIR_EDGE_RST 5'h00
`define EIR_EN_RST 12'h000
`define EIR_TMR_RST 8'h0f
`define EIR_VEC_BASE 14'h0010
`define EIR_CE_PREV_RST 6'h20

`endif

// *** common/eir_pkg.sv ***
/*
 * Types shared by the interrupt front end: the APB request and answer and
 * the core-side request and answer bundles.
 * Assumes eir_consts.svh is on the include path.
 */
`include "eir_consts.svh"

package eir_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`EIR_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } eir_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } eir_apb_rsp_t;

    typedef struct packed {
        logic [`EIR_PC_W-1:0] pc;
        logic [3:0] bank;
        logic [3:0] index;
        logic irq_return_instr;
        logic sub_return_instr;
        logic sub_return_skip_instr;
        logic global_enable_instr;
        logic global_disable_instr;
    } eir_cpu_in_t;

    typedef struct packed {
        logic pc_load;
        logic [`EIR_PC_W-1:0] pc_value;
        logic sys_load;
        logic [3:0] bank;
        logic [3:0] index;
    } eir_cpu_out_t;

    typedef enum logic [1:0] {
        RET_NONE,
        RET_IRQ,
        RET_SUB,
        RET_SUB_SKIP
    } eir_ret_kind_t;

endpackage : eir_pkg

// *** rtl/eir_pin_filter.sv ***
/*
 * Synchroniser and pulse filter for one request pin.
 * Assumes the pin is asynchronous to pclk; the level only follows after it
 * has stood still for FILT_CYC cycles.
 */
`include "eir_consts.svh"

module eir_pin_filter #(
    parameter int FILT_CYC = `EIR_FILT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level
);
    import eir_pkg::*;

    logic sync1_r;
    logic sync2_r;
    logic level_r;
    logic [7:0] cnt_r;

    wire differs = sync2_r != level_r;
    wire settled = cnt_r == 8'(FILT_CYC - 1);

    // Two flops ahead of any logic keep metastability off the edge detector.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
        end
    end

    // A change shorter than the filter time restarts the count and is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h00;
            level_r <= 1'b0;
        end else if (!differs) begin
            cnt_r <= 8'h00;
        end else if (settled) begin
            cnt_r <= 8'h00;
            level_r <= sync2_r;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    assign level = level_r;

endmodule : eir_pin_filter

// *** rtl/eir_ctrl.sv ***
/*
 * Interrupt front end with return sequencing: six filtered request pins,
 * four modulo timers, two serial sources, acceptance and the return stacks.
 * Assumes the core pulses its instruction strobes for one pclk and that
 * software reaches the registers over APB with zero wait states.
 */
`include "eir_consts.svh"

module eir_ctrl #(
    parameter int SP_DEPTH = 8,
    parameter int TMR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire eir_pkg::eir_apb_req_t apb_i,
    output eir_pkg::eir_apb_rsp_t apb_o,
    input wire eir_pkg::eir_cpu_in_t cpu_i,
    output eir_pkg::eir_cpu_out_t cpu_o,
    input wire logic ext_req_pin_a,
    input wire logic ext_req_pin_b,
    input wire logic ext_req_pin_c,
    input wire logic ext_req_pin_d,
    input wire logic ext_req_pin_e,
    input wire logic ce_pin,
    input wire logic wdt_stack_reset,
    input wire logic ce_reset,
    input wire logic [1:0] serial_done,
    output logic [2:0] in_port_3b,
    output logic [1:0] gp_port_2b
);
    import eir_pkg::*;

    localparam int SPW = $clog2(SP_DEPTH);
    localparam int NSRC = `EIR_NSRC;
    localparam int INSTR_MAX = 446;

    // Instruction-cycle divider: every slower event runs on this enable.
    logic [8:0] div_r;
    wire tick = div_r == 9'(`EIR_INSTR_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 9'h000;
        end else begin
            div_r <= tick ? 9'h000 : div_r + 9'h001;
        end
    end

    // Pins, filtering and edge detection.
    logic [5:0] lvl;
    logic [5:0] eff_prev_r;
    logic [4:0] edge_sel_r;
    wire [5:0] pin_raw = {ce_pin, ext_req_pin_e, ext_req_pin_d, ext_req_pin_c, ext_req_pin_b, ext_req_pin_a};

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_pin
            eir_pin_filter #(.FILT_CYC(`EIR_FILT_CYC)) u_filt (
                .pclk(pclk),
                .presetn(presetn),
                .pin(pin_raw[g]),
                .level(lvl[g])
            );
        end
    endgenerate

    // The select bit flips the level, so a select write away from the present
    // level looks like a fresh edge and one toward it looks like none.
    wire [5:0] eff = lvl ^ {1'b1, edge_sel_r};
    wire [5:0] pin_rise = eff & ~eff_prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eff_prev_r <= `EIR_CE_PREV_RST;
        end else begin
            eff_prev_r <= eff;
        end
    end

    // APB slave: zero wait states, data and ready registered in setup.
    wire setup = apb_i.psel & ~apb_i.penable;
    wire [`EIR_IDX_W-1:0] idx = apb_i.paddr[`EIR_ADDR_W-1:2];
    wire aligned = apb_i.paddr[1:0] == 2'b00;
    wire wr_en = apb_i.psel & apb_i.penable & apb_i.pwrite & apb_o.pready & ~apb_o.pslverr;
    wire [31:0] wd = apb_i.pwdata;

    logic [NSRC-1:0] req_r;
    logic [NSRC-1:0] en_r;
    logic gie_r;
    logic ei_pend_r;
    logic [SPW-1:0] sp_r;
    logic [TMR_W-1:0] tmr_ivl_r [4];
    logic [TMR_W-1:0] tmr_cnt_r [4];
    logic [3:0] tmr_evt;
    logic [31:0] rd;
    logic hit;

    always_comb begin
        rd = 32'h0000_0000;
        hit = aligned;
        if (idx == `EIR_IDX_REQ) begin
            rd = 32'(req_r);
        end else if (idx == `EIR_IDX_EN) begin
            rd = 32'(en_r);
        end else if (idx == `EIR_IDX_STAT) begin
            rd = (32'(sp_r) << `EIR_STAT_SP_POS) | 32'(gie_r);
        end else if (idx == `EIR_IDX_LVL) begin
            rd = 32'(lvl[4:0]);
        end else if (idx == `EIR_IDX_EDGE_HI) begin
            rd = 32'(edge_sel_r[4:3]);
        end else if (idx == `EIR_IDX_EDGE) begin
            rd = {28'h0000000, 1'b0, edge_sel_r[2:0]};
        end else if (idx[`EIR_IDX_W-1:2] == `EIR_IDX_TMR0 >> 2) begin
            rd = 32'(tmr_ivl_r[idx[1:0]]);
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_o <= '0;
        end else begin
            apb_o.pready <= setup;
            apb_o.pslverr <= setup & ~hit;
            apb_o.prdata <= (setup & hit & ~apb_i.pwrite) ? rd : 32'h0000_0000;
        end
    end

    wire wr_req = wr_en && idx == `EIR_IDX_REQ;
    wire wr_en_reg = wr_en && idx == `EIR_IDX_EN;
    wire wr_edge = wr_en && idx == `EIR_IDX_EDGE;
    wire wr_edge_hi = wr_en && idx == `EIR_IDX_EDGE_HI;

    // Edge selects survive a CE reset; only power-on and watchdog clear them.
    logic [4:0] edge_sel_nxt;
    assign edge_sel_nxt = wr_edge ? {edge_sel_r[4:3], wd[2:0]} :
                          wr_edge_hi ? {wd[1:0], edge_sel_r[2:0]} : edge_sel_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_sel_r <= `EIR_EDGE_RST;
        end else if (wdt_stack_reset) begin
            edge_sel_r <= `EIR_EDGE_RST;
        end else begin
            edge_sel_r <= edge_sel_nxt;
        end
    end

    // Modulo timers count instruction cycles.
    generate
        for (g = 0; g < 4; g++) begin : g_tmr
            wire wr_ivl = wr_en && idx == `EIR_IDX_TMR0 + `EIR_IDX_W'(g);
            wire wrap = tmr_cnt_r[g] == tmr_ivl_r[g];
            assign tmr_evt[g] = tick & wrap;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tmr_ivl_r[g] <= TMR_W'(`EIR_TMR_RST);
                    tmr_cnt_r[g] <= '0;
                end else begin
                    if (wr_ivl) begin
                        tmr_ivl_r[g] <= wd[TMR_W-1:0];
                    end
                    if (wr_ivl || tmr_evt[g]) begin
                        tmr_cnt_r[g] <= '0;
                    end else if (tick) begin
                        tmr_cnt_r[g] <= tmr_cnt_r[g] + 1'b1;
                    end
                end
            end
        end
    endgenerate

    // Request flags: hardware set wins over software or acceptance clear.
    eir_ret_kind_t ret_kind_r;
    // CE takes bit 0 so that the lowest set bit is also the highest priority.
    wire [5:0] pin_set = {pin_rise[4:0], pin_rise[5]};
    wire [NSRC-1:0] src_set = {serial_done, tmr_evt, pin_set};
    wire [NSRC-1:0] pend = req_r & en_r;
    wire [NSRC-1:0] grant = pend & (~pend + 1'b1);
    wire ret_go = tick && ret_kind_r != RET_NONE;
    wire accept = tick & gie_r & (|pend) & ~ret_go;
    wire [NSRC-1:0] req_clr = (wr_req ? wd[NSRC-1:0] : '0) | (accept ? grant : '0);
    wire [NSRC-1:0] req_nxt = (req_r & ~req_clr) | src_set;

    logic [3:0] grant_idx;
    always_comb begin
        grant_idx = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                grant_idx = 4'(i);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_r <= '0;
            en_r <= `EIR_EN_RST;
        end else begin
            req_r <= wdt_stack_reset ? '0 : req_nxt;
            en_r <= wr_en_reg ? wd[NSRC-1:0] : en_r;
        end
    end

    // Global enable: the enable instruction acts at the next instruction-cycle boundary,
    // the disable instruction and acceptance act at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_r <= 1'b0;
            ei_pend_r <= 1'b0;
        end else if (wdt_stack_reset || ce_reset || cpu_i.global_disable_instr || accept) begin
            gie_r <= 1'b0;
            ei_pend_r <= 1'b0;
        end else if (cpu_i.global_enable_instr) begin
            ei_pend_r <= 1'b1;
        end else if (tick && ei_pend_r) begin
            gie_r <= 1'b1;
            ei_pend_r <= 1'b0;
        end
    end

    // Return requests wait for the next instruction-cycle boundary.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ret_kind_r <= RET_NONE;
        end else if (cpu_i.irq_return_instr) begin
            ret_kind_r <= RET_IRQ;
        end else if (cpu_i.sub_return_skip_instr) begin
            ret_kind_r <= RET_SUB_SKIP;
        end else if (cpu_i.sub_return_instr) begin
            ret_kind_r <= RET_SUB;
        end else if (ret_go) begin
            ret_kind_r <= RET_NONE;
        end
    end

    // Address and interrupt stacks; no reset, software never reads stale slots.
    logic [`EIR_PC_W-1:0] astack [SP_DEPTH];
    logic [7:0] istack [SP_DEPTH];
    wire [SPW-1:0] sp_dec = sp_r - 1'b1;

    always_ff @(posedge pclk) begin
        if (accept) begin
            astack[sp_dec] <= cpu_i.pc;
            istack[sp_dec] <= {cpu_i.bank, cpu_i.index};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_r <= '0;
        end else if (wdt_stack_reset) begin
            sp_r <= '0;
        end else if (accept) begin
            sp_r <= sp_dec;
        end else if (ret_go) begin
            sp_r <= sp_r + 1'b1;
        end
    end

    // Whole return or vector load lands in one registered step.
    wire [`EIR_PC_W-1:0] skip_add = (ret_kind_r == RET_SUB_SKIP) ? `EIR_PC_W'(1) : '0;
    wire [`EIR_PC_W-1:0] vec_pc = `EIR_VEC_BASE + `EIR_PC_W'(grant_idx);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_o <= '0;
        end else begin
            cpu_o.pc_load <= ret_go | accept;
            cpu_o.sys_load <= ret_go && ret_kind_r == RET_IRQ;
            if (ret_go) begin
                cpu_o.pc_value <= astack[sp_r] + skip_add;
                {cpu_o.bank, cpu_o.index} <= istack[sp_r];
            end else if (accept) begin
                cpu_o.pc_value <= vec_pc;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_port_3b <= 3'h0;
            gp_port_2b <= 2'h0;
        end else begin
            in_port_3b <= lvl[2:0];
            gp_port_2b <= lvl[4:3];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ret_done;
        ##[1:INSTR_MAX] cpu_o.pc_load;
    endsequence

    a_ret_within_cycle: assert property ($rose(ret_kind_r != RET_NONE) |-> s_ret_done)
        else $error("return not completed within one instruction cycle");
    a_ret_sp_inc: assert property (ret_go && !wdt_stack_reset |=> sp_r == $past(sp_r) + 1'b1)
        else $error("return did not increment stack pointer");
    a_sub_no_sys: assert property (ret_go && ret_kind_r != RET_IRQ |=> cpu_o.pc_load && !cpu_o.sys_load)
        else $error("subroutine return restored bank or index");
    a_accept_gated: assert property (accept |-> gie_r && (req_r & en_r & grant) == grant)
        else $error("interrupt accepted without all three enables");
    a_accept_prio: assert property (accept |-> (pend & (grant - 1'b1)) == '0 && $onehot(grant))
        else $error("lower priority source won");
    a_accept_effects: assert property (accept && !wdt_stack_reset |=> !gie_r && sp_r == $past(sp_r) - 1'b1
                                       && cpu_o.pc_value == $past(vec_pc))
        else $error("acceptance did not clear enable, push and vector");
    a_edge_sets_flag: assert property (|pin_set && !wdt_stack_reset |=> (req_r[5:0] & $past(pin_set)) == $past(pin_set))
        else $error("detected edge did not set its flag");
    a_flag_holds: assert property (!(|src_set) && !wr_req && !accept && !wdt_stack_reset |=> req_r == $past(req_r))
        else $error("request flag changed without cause");
    a_edge_wdt_clear: assert property (wdt_stack_reset |=> edge_sel_r == '0)
        else $error("watchdog reset did not clear edge selects");
    a_edge_ce_keep: assert property (ce_reset && !wdt_stack_reset && !wr_edge && !wr_edge_hi
                                     |=> edge_sel_r == $past(edge_sel_r))
        else $error("CE reset disturbed edge selects");

endmodule : eir_ctrl

// *** verif/eir_far_side.sv ***
/*
 * Far side of the interrupt front end: the request pins, the chip-enable pin
 * and the serial completion strobes.
 * Assumes the bench calls its tasks; every change lands just after a pclk edge.
 */
module eir_far_side (
    input wire logic pclk,
    output logic ext_req_pin_a,
    output logic ext_req_pin_b,
    output logic ext_req_pin_c,
    output logic ext_req_pin_d,
    output logic ext_req_pin_e,
    output logic ce_pin,
    output logic [1:0] serial_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] lvl = 6'h00;
    logic [1:0] done = 2'h0;

    assign {ce_pin, ext_req_pin_e, ext_req_pin_d, ext_req_pin_c, ext_req_pin_b, ext_req_pin_a} = lvl;
    assign serial_done = done;

    task automatic drive(input int idx, input logic v);
        @(posedge pclk);
        lvl[idx] <= v;
    endtask : drive

    // Pins are driven push-pull by the source, so a released pulse returns low.
    task automatic pulse(input int idx, input int cyc);
        drive(idx, 1'b1);
        repeat (cyc) @(posedge pclk);
        lvl[idx] <= 1'b0;
    endtask : pulse

    task automatic serial(input logic [1:0] v);
        @(posedge pclk);
        done <= v;
        @(posedge pclk);
        done <= 2'h0;
    endtask : serial
endmodule : eir_far_side

// *** verif/eir_ctrl_bench.sv ***
/*
 * Self-checking bench of the interrupt front end, driving APB and core strobes.
 * Assumes eir_far_side as pin source and the package and constants header.
 */
`include "eir_consts.svh"

module eir_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import eir_pkg::*;
    localparam logic [11:0] A_REQ = {`EIR_IDX_REQ, 2'b00};
    localparam logic [11:0] A_EN = {`EIR_IDX_EN, 2'b00};
    localparam logic [11:0] A_STAT = {`EIR_IDX_STAT, 2'b00};
    localparam logic [11:0] A_LVL = {`EIR_IDX_LVL, 2'b00};
    localparam logic [11:0] A_EHI = {`EIR_IDX_EDGE_HI, 2'b00};
    localparam logic [11:0] A_TMR = {`EIR_IDX_TMR0, 2'b00};
    localparam logic [11:0] A_EDGE = {`EIR_IDX_EDGE, 2'b00};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic wdt_rst = 1'b0;
    logic ce_rst = 1'b0;
    eir_apb_req_t req = '0;
    eir_apb_rsp_t rsp;
    eir_cpu_in_t cpu = '0;
    eir_cpu_out_t cout;
    wire logic pa, pb, pc, pd, pe, ce;
    wire logic [1:0] sdone;
    logic [2:0] p3;
    logic [1:0] p2;
    logic [31:0] rd;
    logic err;
    logic [2:0] sp0;
    int n_fail = 0;
    int samples_checked = 0;

    always #2 pclk = ~pclk;

    eir_ctrl #(.SP_DEPTH(8), .TMR_W(8)) eir_ctrl_inst (.pclk(pclk), .presetn(presetn), .apb_i(req), .apb_o(rsp),
        .cpu_i(cpu), .cpu_o(cout), .ext_req_pin_a(pa), .ext_req_pin_b(pb), .ext_req_pin_c(pc), .ext_req_pin_d(pd),
        .ext_req_pin_e(pe), .ce_pin(ce), .wdt_stack_reset(wdt_rst), .ce_reset(ce_rst), .serial_done(sdone),
        .in_port_3b(p3), .gp_port_2b(p2));
    eir_far_side eir_far_side_inst (.pclk(pclk), .ext_req_pin_a(pa), .ext_req_pin_b(pb), .ext_req_pin_c(pc),
        .ext_req_pin_d(pd), .ext_req_pin_e(pe), .ce_pin(ce), .serial_done(sdone));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        chk("pready", 32'h1, {31'h0, rsp.pready});
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd & m);
    endtask : rd_chk

    // Order: interrupt return, subroutine return, skip return, enable, disable.
    task automatic strobe(input logic [4:0] s);
        @(posedge pclk);
        {cpu.irq_return_instr, cpu.sub_return_instr, cpu.sub_return_skip_instr, cpu.global_enable_instr,
            cpu.global_disable_instr} <= s;
        @(posedge pclk);
        {cpu.irq_return_instr, cpu.sub_return_instr, cpu.sub_return_skip_instr, cpu.global_enable_instr,
            cpu.global_disable_instr} <= 5'h00;
    endtask : strobe

    task automatic wait_load(input logic [13:0] pcv, input logic sys, input int lim);
        int n;
        n = 0;
        @(negedge pclk);
        while (cout.pc_load !== 1'b1 && n < lim) begin
            @(negedge pclk);
            n++;
        end
        chk("pc_load", 32'h1, {31'h0, cout.pc_load});
        chk("pc_value", {18'h0, pcv}, {18'h0, cout.pc_value});
        chk("sys_load", {31'h0, sys}, {31'h0, cout.sys_load});
    endtask : wait_load

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #(4 * 40000);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        cpu.pc = 14'h1234;
        cpu.bank = 4'ha;
        cpu.index = 4'h5;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("edge_sel", A_EDGE, 32'h0, 32'hffffffff);
        apb(1'b1, A_EDGE, 32'h0000000f);
        rd_chk("edge_sel", A_EDGE, 32'h7, 32'hffffffff);
        apb(1'b0, 12'h041, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        apb(1'b0, 12'h080, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        apb(1'b1, A_EDGE, 32'h0);
        apb(1'b1, A_REQ, 32'h00000fff);
        eir_far_side_inst.drive(0, 1'b1);
        eir_far_side_inst.drive(3, 1'b1);
        eir_far_side_inst.pulse(2, 10);
        repeat (40) @(posedge pclk);
        rd_chk("flags", A_REQ, 32'h12, 32'h3e);
        rd_chk("levels", A_LVL, 32'h9, 32'h1f);
        chk("in_port", 32'h1, {29'h0, p3});
        chk("gp_port", 32'h1, {30'h0, p2});
        apb(1'b1, A_REQ, 32'h0000003e);
        apb(1'b1, A_EDGE, 32'h1);
        rd_chk("flags", A_REQ, 32'h0, 32'h3e);
        apb(1'b1, A_EDGE, 32'h2);
        rd_chk("flags", A_REQ, 32'h6, 32'h3e);
        apb(1'b1, A_REQ, 32'h0000003f);
        eir_far_side_inst.drive(1, 1'b1);
        repeat (40) @(posedge pclk);
        rd_chk("flags", A_REQ, 32'h0, 32'h3e);
        eir_far_side_inst.drive(1, 1'b0);
        eir_far_side_inst.drive(5, 1'b1);
        repeat (40) @(posedge pclk);
        eir_far_side_inst.drive(5, 1'b0);
        repeat (40) @(posedge pclk);
        rd_chk("flags", A_REQ, 32'h5, 32'h3f);
        apb(1'b1, A_REQ, 32'h0000003f);
        apb(1'b1, A_TMR, 32'h1);
        rd_chk("tmr_ivl", A_TMR, 32'h1, 32'hff);
        apb(1'b1, A_REQ, 32'h00000040);
        repeat (1000) @(posedge pclk);
        rd_chk("timer_flag", A_REQ, 32'h40, 32'h40);
        apb(1'b1, A_EDGE, 32'h1);
        apb(1'b1, A_EDGE, 32'h0);
        apb(1'b0, A_STAT, 32'h0);
        sp0 = rd[`EIR_STAT_SP_POS+:3];
        apb(1'b1, A_EN, 32'h2);
        strobe(5'b00010);
        wait_load(14'h0011, 1'b0, 1200);
        rd_chk("flags", A_REQ, 32'h0, 32'h2);
        rd_chk("status", A_STAT, {21'h0, sp0 - 3'h1, 8'h0}, 32'h701);
        cpu.bank <= 4'h3;
        cpu.pc <= 14'h0abc;
        strobe(5'b10000);
        wait_load(14'h1234, 1'b1, 450);
        chk("bank", 32'ha, {28'h0, cout.bank});
        chk("index", 32'h5, {28'h0, cout.index});
        rd_chk("status", A_STAT, {21'h0, sp0, 8'h0}, 32'h700);
        eir_far_side_inst.serial(2'b11);
        apb(1'b1, A_EN, 32'h00000c00);
        strobe(5'b00010);
        wait_load(14'h001a, 1'b0, 1200);
        strobe(5'b00100);
        wait_load(14'h0abd, 1'b0, 450);
        strobe(5'b00010);
        wait_load(14'h001b, 1'b0, 1200);
        strobe(5'b01000);
        wait_load(14'h0abc, 1'b0, 450);
        apb(1'b1, A_EN, 32'h0);
        strobe(5'b00010);
        repeat (1000) @(posedge pclk);
        rd_chk("gie", A_STAT, 32'h1, 32'h1);
        strobe(5'b00001);
        rd_chk("gie", A_STAT, 32'h0, 32'h1);
        apb(1'b1, A_EDGE, 32'h5);
        apb(1'b1, A_EHI, 32'h3);
        @(posedge pclk);
        ce_rst <= 1'b1;
        @(posedge pclk);
        ce_rst <= 1'b0;
        rd_chk("edge_sel", A_EDGE, 32'h5, 32'hf);
        rd_chk("edge_hi", A_EHI, 32'h3, 32'h3);
        @(posedge pclk);
        wdt_rst <= 1'b1;
        @(posedge pclk);
        wdt_rst <= 1'b0;
        rd_chk("edge_sel", A_EDGE, 32'h0, 32'hf);
        rd_chk("edge_hi", A_EHI, 32'h0, 32'h3);
        tally_and_finish();
    end
endmodule : eir_ctrl_bench
